// ### verilog/dspsc_pkg.sv
// Shared constants and types of the dual-slot power switch serial control
`default_nettype none
package dspsc_pkg;
    // Control word layout
    localparam int WORD_W = 9;
    localparam int ENABLE_BIT = 8;
    localparam int SLOT_B_LSB = 4;
    localparam int SLOT_A_LSB = 0;
    // Field positions inside one slot nibble
    localparam int SUPPLY_HIGH_POS = 3;
    localparam int SUPPLY_LOW_POS = 2;
    localparam int PROG_FOLLOW_POS = 1;
    localparam int PROG_HIGH_POS = 0;
    localparam logic [WORD_W-1:0] WORD_RESET = 9'h000;

    // Output levels of one switch
    typedef enum logic [2:0] {
        LVL_HIZ = 3'h0,
        LVL_GND = 3'h1,
        LVL_3V3 = 3'h2,
        LVL_5V  = 3'h3,
        LVL_12V = 3'h4
    } dspsc_level_t;

    // Link timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_SU_DATA_NS = 75;
    localparam int T_HD_DATA_NS = 75;
    localparam int T_SU_LATCH_NS = 50;
    localparam int T_W_LATCH_NS = 100;
    localparam int T_W_CLK_NS = 50;
    localparam int T_LINK_PERIOD_MIN_NS = 500;
    localparam int SU_LATCH_CYC = (T_SU_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCH_W_CYC = (T_W_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_MIN_CYC =
        (T_LINK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SU_DATA_CYC = (T_SU_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HD_DATA_CYC = (T_HD_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int W_CLK_CYC = (T_W_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host command port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_WORD = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_FAULT_A_POS = 1;
    localparam int ST_FAULT_B_POS = 2;

    // Host sequencer states
    typedef enum logic [4:0] {
        H_IDLE   = 5'h01,
        H_LOW    = 5'h02,
        H_HIGH   = 5'h04,
        H_SETTLE = 5'h08,
        H_LATCH  = 5'h10
    } dspsc_hstate_t;
endpackage
`default_nettype wire

// ### verilog/dspsc_link_if.sv
// Three-wire control link with the two slot fault lines
`timescale 1ns/1ps
`default_nettype none
interface dspsc_link_if;
    logic sdata;
    logic sclk;
    logic latch;
    logic fault_a_n;
    logic fault_b_n;

    // Switch end
    modport dev (
        input sdata,
        input sclk,
        input latch,
        output fault_a_n,
        output fault_b_n
    );

    // Controller end
    modport host (
        output sdata,
        output sclk,
        output latch,
        input fault_a_n,
        input fault_b_n
    );
endinterface
`default_nettype wire

// ### verilog/dspsc_switch.sv
// Switch end: serial shift register, latch capture and output decode
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dspsc_switch (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    dspsc_link_if.dev link,
    output dspsc_pkg::dspsc_level_t supply_a_out,
    output dspsc_pkg::dspsc_level_t prog_a_out,
    output dspsc_pkg::dspsc_level_t supply_b_out,
    output dspsc_pkg::dspsc_level_t prog_b_out,
    output logic [dspsc_pkg::WORD_W-1:0] active_word_out
);
    import dspsc_pkg::*;

    // Core state, clocked by the local clock
    typedef struct packed {
        logic latch_meta;
        logic latch_sync;
        logic latch_prev;
        logic [WORD_W-1:0] word;
        dspsc_level_t supply_a;
        dspsc_level_t prog_a;
        dspsc_level_t supply_b;
        dspsc_level_t prog_b;
        logic fault_a_n;
        logic fault_b_n;
    } dspsc_core_t;

    // Link state, clocked by the serial clock
    typedef struct packed {
        logic [WORD_W-1:0] shift;
    } dspsc_shift_t;

    localparam dspsc_core_t CORE_RESET = '{
        latch_meta: 1'b0,
        latch_sync: 1'b0,
        latch_prev: 1'b0,
        word: WORD_RESET,
        supply_a: LVL_GND,
        prog_a: LVL_GND,
        supply_b: LVL_GND,
        prog_b: LVL_GND,
        fault_a_n: 1'b1,
        fault_b_n: 1'b1
    };

    dspsc_core_t core_ff;
    dspsc_core_t nxt_core;
    dspsc_shift_t shift_ff;
    dspsc_shift_t nxt_shift;

    // Supply decode; slot B swaps the meaning of the two codes
    function automatic dspsc_level_t supply_decode(input logic high_sel,
                                                   input logic low_sel,
                                                   input logic swapped);
        dspsc_level_t lvl;
        lvl = LVL_GND;
        case ({high_sel, low_sel})
            2'h1: lvl = swapped ? LVL_5V : LVL_3V3;
            2'h2: lvl = swapped ? LVL_3V3 : LVL_5V;
            default: lvl = LVL_GND;
        endcase
        return lvl;
    endfunction

    // Programming decode against the slot's decoded supply
    function automatic dspsc_level_t prog_decode(input logic follow_sel,
                                                 input logic high_sel,
                                                 input dspsc_level_t supply);
        dspsc_level_t lvl;
        lvl = LVL_GND;
        case ({follow_sel, high_sel})
            2'h0: lvl = LVL_GND;
            2'h1: lvl = LVL_12V;
            2'h2: lvl = (supply == LVL_GND) ? LVL_GND : supply;
            2'h3:
            begin
                // The opposite supply rail, floating when the slot is off
                if (supply == LVL_3V3)
                    lvl = LVL_5V;
                else if (supply == LVL_5V)
                    lvl = LVL_3V3;
                else
                    lvl = LVL_HIZ;
            end
            default: lvl = LVL_GND;
        endcase
        return lvl;
    endfunction

    // 12V programming on an unpowered slot is the error case
    function automatic logic fault_n_of(input dspsc_level_t supply,
                                        input dspsc_level_t prog);
        return !((prog == LVL_12V) && (supply == LVL_GND));
    endfunction

    // Shift on every serial clock rise; no edge is needed after the last bit
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_shift.shift = {shift_ff.shift[WORD_W-2:0], link.sdata};
    end

    // Link domain register; a stopped clock simply holds the word
    always_ff @(posedge link.sclk or negedge reset_n_in)
    begin
        if (!reset_n_in)
            shift_ff <= '{shift: WORD_RESET};
        else
            shift_ff <= nxt_shift;
    end

    // Latch edge capture and decode in the local domain
    always_comb
    begin
        logic [WORD_W-1:0] w;
        dspsc_level_t sa;
        dspsc_level_t sb;
        w = '0;
        sa = LVL_GND;
        sb = LVL_GND;
        nxt_core = core_ff;
        // Two flops before the edge detector looks at the latch
        nxt_core.latch_meta = link.latch;
        nxt_core.latch_sync = core_ff.latch_meta;
        nxt_core.latch_prev = core_ff.latch_sync;
        // Shift word is quiet while the latch is high, so it crosses static
        if (core_ff.latch_sync && !core_ff.latch_prev)
        begin
            w = shift_ff.shift;
            nxt_core.word = w;
            if (!w[ENABLE_BIT])
            begin
                // Slot bits are don't-care while disabled
                nxt_core.supply_a = LVL_HIZ;
                nxt_core.prog_a = LVL_HIZ;
                nxt_core.supply_b = LVL_HIZ;
                nxt_core.prog_b = LVL_HIZ;
            end
            else
            begin
                sa = supply_decode(w[SLOT_A_LSB + SUPPLY_HIGH_POS],
                                   w[SLOT_A_LSB + SUPPLY_LOW_POS], 1'b0);
                sb = supply_decode(w[SLOT_B_LSB + SUPPLY_HIGH_POS],
                                   w[SLOT_B_LSB + SUPPLY_LOW_POS], 1'b1);
                nxt_core.supply_a = sa;
                nxt_core.supply_b = sb;
                nxt_core.prog_a = prog_decode(w[SLOT_A_LSB + PROG_FOLLOW_POS],
                                              w[SLOT_A_LSB + PROG_HIGH_POS], sa);
                nxt_core.prog_b = prog_decode(w[SLOT_B_LSB + PROG_FOLLOW_POS],
                                              w[SLOT_B_LSB + PROG_HIGH_POS], sb);
            end
            // Illegal codes are still decoded, but flagged
            nxt_core.fault_a_n = fault_n_of(nxt_core.supply_a, nxt_core.prog_a);
            nxt_core.fault_b_n = fault_n_of(nxt_core.supply_b, nxt_core.prog_b);
        end
    end

    // Core register; outputs sit clamped at ground until the first latch
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            core_ff <= CORE_RESET;
        else
            core_ff <= nxt_core;
    end

    // Outputs straight from flops
    assign supply_a_out = core_ff.supply_a;
    assign prog_a_out = core_ff.prog_a;
    assign supply_b_out = core_ff.supply_b;
    assign prog_b_out = core_ff.prog_b;
    assign active_word_out = core_ff.word;
    assign link.fault_a_n = core_ff.fault_a_n;
    assign link.fault_b_n = core_ff.fault_b_n;
endmodule
`default_nettype wire

// ### verilog/dspsc_host.sv
// Controller end: command registers and three-wire word sender
`timescale 1ns/1ps
`default_nettype none
module dspsc_host #(
    parameter int HALF_CYC = dspsc_pkg::HALF_MIN_CYC,
    parameter int LATCH_CYC = dspsc_pkg::LATCH_W_CYC
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [dspsc_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [dspsc_pkg::DATA_W-1:0] cmd_wdata_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    output logic [dspsc_pkg::DATA_W-1:0] cmd_rdata_out,
    output logic busy_out,
    dspsc_link_if.host link
);
    import dspsc_pkg::*;

    // Half period covers data setup, hold, clock width and the 2MHz limit
    if (HALF_CYC < HALF_MIN_CYC || HALF_CYC < SU_LATCH_CYC || HALF_CYC > 255)
        $error("dspsc_host: HALF_CYC out of range");
    if (LATCH_CYC < LATCH_W_CYC || LATCH_CYC > 255)
        $error("dspsc_host: LATCH_CYC out of range");

    localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);
    localparam logic [7:0] LATCH_LOAD = 8'(LATCH_CYC - 1);
    localparam logic [3:0] BITS_LOAD = 4'(WORD_W);

    typedef struct packed {
        dspsc_hstate_t state;
        logic [7:0] cnt;
        logic [3:0] bits;
        logic [WORD_W-1:0] shreg;
        logic [WORD_W-1:0] word;
        logic sclk;
        logic sdata;
        logic latch;
        logic [1:0] fa_sync;
        logic [1:0] fb_sync;
        logic [DATA_W-1:0] rdata;
    } dspsc_host_t;

    dspsc_host_t st_ff;
    dspsc_host_t nxt_st;

    // Sequencer, fault synchronisers and register port
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.fa_sync = {st_ff.fa_sync[0], link.fault_a_n};
        nxt_st.fb_sync = {st_ff.fb_sync[0], link.fault_b_n};
        nxt_st.cnt = st_ff.cnt - 8'h01;
        case (st_ff.state)
            H_IDLE:
            begin
                nxt_st.cnt = st_ff.cnt;
                // A write while busy is ignored; software polls busy first
                if (cmd_wr_in && cmd_addr_in == REG_WORD)
                begin
                    nxt_st.word = cmd_wdata_in[WORD_W-1:0];
                    nxt_st.shreg = cmd_wdata_in[WORD_W-1:0];
                    nxt_st.sdata = cmd_wdata_in[WORD_W-1];
                    nxt_st.bits = BITS_LOAD;
                    nxt_st.cnt = HALF_LOAD;
                    nxt_st.state = H_LOW;
                end
            end
            H_LOW:
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.cnt = HALF_LOAD;
                    nxt_st.state = H_HIGH;
                end
            H_HIGH:
                if (st_ff.cnt == 8'h00)
                begin
                    // Data changes on the falling edge, mid-way between rises
                    nxt_st.sclk = 1'b0;
                    nxt_st.cnt = HALF_LOAD;
                    if (st_ff.bits == 4'h1)
                        nxt_st.state = H_SETTLE;
                    else
                    begin
                        nxt_st.bits = st_ff.bits - 4'h1;
                        nxt_st.shreg = {st_ff.shreg[WORD_W-2:0], 1'b0};
                        nxt_st.sdata = st_ff.shreg[WORD_W-2];
                        nxt_st.state = H_LOW;
                    end
                end
            H_SETTLE:
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.latch = 1'b1;
                    nxt_st.cnt = LATCH_LOAD;
                    nxt_st.state = H_LATCH;
                end
            H_LATCH:
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.latch = 1'b0;
                    nxt_st.state = H_IDLE;
                end
            default: nxt_st.state = H_IDLE;
        endcase
        // Read data stands only in the cycle after the strobe
        nxt_st.rdata = '0;
        if (cmd_rd_in)
        begin
            if (cmd_addr_in == REG_WORD)
                nxt_st.rdata = DATA_W'(st_ff.word);
            else if (cmd_addr_in == REG_STATUS)
            begin
                nxt_st.rdata[ST_BUSY_POS] = (st_ff.state != H_IDLE);
                nxt_st.rdata[ST_FAULT_A_POS] = !st_ff.fa_sync[1];
                nxt_st.rdata[ST_FAULT_B_POS] = !st_ff.fb_sync[1];
            end
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_ff <= '0;
            st_ff.state <= H_IDLE;
            st_ff.fa_sync <= 2'h3;
            st_ff.fb_sync <= 2'h3;
        end
        else
            st_ff <= nxt_st;
    end

    assign link.sclk = st_ff.sclk;
    assign link.sdata = st_ff.sdata;
    assign link.latch = st_ff.latch;
    assign cmd_rdata_out = st_ff.rdata;
    assign busy_out = (st_ff.state != H_IDLE);
endmodule
`default_nettype wire

// ### dv/dspsc_checker.sv
// Concurrent checks on the link and the switch outputs
`timescale 1ns/1ps
`default_nettype none
module dspsc_checker #(
    parameter int HALF_CYC = 10,
    parameter int LATCH_CYC = 4
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic sdata,
    input wire logic sclk,
    input wire logic latch,
    input wire logic fault_a_n,
    input wire logic fault_b_n,
    input wire dspsc_pkg::dspsc_level_t supply_a_out,
    input wire dspsc_pkg::dspsc_level_t prog_a_out,
    input wire dspsc_pkg::dspsc_level_t supply_b_out,
    input wire dspsc_pkg::dspsc_level_t prog_b_out,
    input wire logic [dspsc_pkg::WORD_W-1:0] active_word_out
);
    import dspsc_pkg::*;
    logic [7:0] hi_cnt_ff;
    logic [7:0] lat_cnt_ff;
    logic [3:0] rises_ff;
    logic sclk_q_ff;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // Phase lengths and rise count, since repetition cannot reach them
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            hi_cnt_ff <= 8'h00;
            lat_cnt_ff <= 8'h00;
            rises_ff <= 4'h0;
            sclk_q_ff <= 1'b0;
        end
        else
        begin
            sclk_q_ff <= sclk;
            hi_cnt_ff <= sclk ? hi_cnt_ff + 8'h01 : 8'h00;
            lat_cnt_ff <= latch ? lat_cnt_ff + 8'h01 : 8'h00;
            if (latch)
                rises_ff <= 4'h0;
            else if (sclk && !sclk_q_ff)
                rises_ff <= rises_ff + 4'h1;
        end
    end
    chk_latch_quiet: assert property (latch |-> !sclk)
        else $error("serial clock high during latch");
    chk_latch_width: assert property ($fell(latch) |-> lat_cnt_ff == LATCH_CYC)
        else $error("latch pulse width wrong");
    chk_sclk_high: assert property ($fell(sclk) |-> hi_cnt_ff == HALF_CYC)
        else $error("serial clock high phase wrong");
    chk_nine_rises: assert property ($rose(latch) |-> rises_ff == WORD_W)
        else $error("word not nine clock rises");
    chk_data_hold: assert property (sclk |-> $stable(sdata))
        else $error("data moved while clock high");
    // Fault flag and levels leave the same flop, so they must agree every cycle
    chk_fault_a: assert property (!fault_a_n ==
        (prog_a_out == LVL_12V && supply_a_out == LVL_GND))
        else $error("slot A fault not flagged");
    chk_fault_b: assert property (!fault_b_n ==
        (prog_b_out == LVL_12V && supply_b_out == LVL_GND))
        else $error("slot B fault not flagged");
    chk_hiz_all: assert property (supply_a_out == LVL_HIZ |->
        prog_a_out == LVL_HIZ && supply_b_out == LVL_HIZ && prog_b_out == LVL_HIZ &&
        !active_word_out[ENABLE_BIT])
        else $error("partial high impedance");
    cover property ($rose(latch));
    cover property (!fault_a_n);
    cover property (supply_b_out == LVL_3V3);
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Controller end driving the switch end over the link, self-checking
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dspsc_pkg::*;
    logic mclk_in;
    logic reset_n_in;
    logic [ADDR_W-1:0] cmd_addr_in;
    logic [DATA_W-1:0] cmd_wdata_in;
    logic cmd_wr_in;
    logic cmd_rd_in;
    logic [DATA_W-1:0] cmd_rdata_out;
    logic busy_out;
    dspsc_level_t supply_a_out, prog_a_out, supply_b_out, prog_b_out;
    logic [WORD_W-1:0] active_word_out;
    logic [DATA_W-1:0] rdata;
    int num_errors;
    int samples_checked;
    dspsc_link_if link_i();
    dspsc_host #(.HALF_CYC(10), .LATCH_CYC(4)) u_dspsc_host (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in), .cmd_rdata_out(cmd_rdata_out),
        .busy_out(busy_out), .link(link_i));
    dspsc_switch u_dspsc_switch (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link_i),
        .supply_a_out(supply_a_out), .prog_a_out(prog_a_out), .supply_b_out(supply_b_out),
        .prog_b_out(prog_b_out), .active_word_out(active_word_out));
    dspsc_checker #(.HALF_CYC(10), .LATCH_CYC(4)) u_dspsc_checker (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .sdata(link_i.sdata), .sclk(link_i.sclk),
        .latch(link_i.latch), .fault_a_n(link_i.fault_a_n), .fault_b_n(link_i.fault_b_n),
        .supply_a_out(supply_a_out), .prog_a_out(prog_a_out), .supply_b_out(supply_b_out),
        .prog_b_out(prog_b_out), .active_word_out(active_word_out));
    // Slot B wires its supply selects crosswise to slot A
    function automatic dspsc_level_t sup(input logic [3:0] n, input logic b);
        if (n[3:2] == 2'h1)
            return b ? LVL_5V : LVL_3V3;
        if (n[3:2] == 2'h2)
            return b ? LVL_3V3 : LVL_5V;
        return LVL_GND;
    endfunction
    // Follow and other-rail codes depend on the decoded supply
    function automatic dspsc_level_t prg(input logic [3:0] n, input logic b);
        dspsc_level_t s;
        s = sup(n, b);
        if (n[1:0] == 2'h0)
            return LVL_GND;
        if (n[1:0] == 2'h1)
            return LVL_12V;
        if (n[1:0] == 2'h2 || s == LVL_GND)
            return n[1:0] == 2'h2 ? s : LVL_HIZ;
        return s == LVL_3V3 ? LVL_5V : LVL_3V3;
    endfunction
    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        cmd_wr_in <= 1'b1;
        cmd_addr_in <= a;
        cmd_wdata_in <= d;
        @(posedge mclk_in);
        cmd_wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_in);
        cmd_rd_in <= 1'b1;
        cmd_addr_in <= a;
        @(posedge mclk_in);
        cmd_rd_in <= 1'b0;
        #1;
        rdata = cmd_rdata_out;
    endtask
    // The active word output must hold the old word until the latch rises
    task automatic wait_idle(input logic [8:0] old);
        logic seen;
        int n;
        seen = 1'b0;
        n = 0;
        do
        begin
            @(posedge mclk_in);
            #1;
            seen = seen | link_i.latch;
            if (!seen && active_word_out !== old)
                chk(1'b0, "selection moved before latch");
            n++;
        end
        while (busy_out !== 1'b0 && n < 2000);
        chk(n < 2000, "busy stuck");
        repeat (6) @(posedge mclk_in);
        #1;
        chk(link_i.sclk === 1'b0, "clock not stopped");
    endtask
    task automatic check_outs(input logic [8:0] w);
        logic e;
        e = w[ENABLE_BIT];
        chk(active_word_out === w, "latched word");
        chk(supply_a_out === (e ? sup(w[3:0], 1'b0) : LVL_HIZ), "supply A");
        chk(prog_a_out === (e ? prg(w[3:0], 1'b0) : LVL_HIZ), "prog A");
        chk(supply_b_out === (e ? sup(w[7:4], 1'b1) : LVL_HIZ), "supply B");
        chk(prog_b_out === (e ? prg(w[7:4], 1'b1) : LVL_HIZ), "prog B");
        chk(link_i.fault_a_n === !(e && w[1:0] == 2'h1 && w[3] == w[2]), "fault A");
        chk(link_i.fault_b_n === !(e && w[5:4] == 2'h1 && w[7] == w[6]), "fault B");
    endtask
    task automatic send(input logic [8:0] w);
        logic [8:0] old;
        old = active_word_out;
        wr(REG_WORD, {7'h00, w});
        wait_idle(old);
        check_outs(w);
    endtask
    task automatic check_rst();
        chk(supply_a_out === LVL_GND && prog_a_out === LVL_GND, "A not grounded");
        chk(supply_b_out === LVL_GND && prog_b_out === LVL_GND, "B not grounded");
        chk(active_word_out === WORD_RESET, "word kept");
        chk(link_i.sclk === 1'b0 && link_i.latch === 1'b0, "link busy");
    endtask
    // Shutdown word first, then every slot code on both slots, illegal ones too
    task automatic test_codes();
        send(9'h0ff);
        for (int i = 0; i < 16; i++)
            send({1'b1, 4'(15 - i), 4'(i)});
        $display("test codes done");
    endtask
    // Status, readback, unmapped space and a word sent while busy
    task automatic test_regs();
        send(9'h151);
        repeat (4) @(posedge mclk_in);
        rd(REG_STATUS);
        chk(rdata[2:0] === 3'h2, "status");
        wr(4'h8, 16'h01ff);
        rd(4'h8);
        chk(rdata === 16'h0000, "unmapped read");
        rd(REG_WORD);
        chk(rdata[8:0] === 9'h151, "readback");
        wr(REG_WORD, 16'h01aa);
        wr(REG_WORD, 16'h0155);
        wait_idle(9'h151);
        check_outs(9'h1aa);
        rd(REG_WORD);
        chk(rdata[8:0] === 9'h1aa, "busy write kept");
        // Slot B 12V on an unpowered slot must show in the status word
        send(9'h110);
        repeat (4) @(posedge mclk_in);
        rd(REG_STATUS);
        chk(rdata[2:0] === 3'h4, "status B");
        $display("test regs done");
    endtask
    // Reset in mid-word, then a clean word afterwards
    task automatic test_midreset();
        wr(REG_WORD, 16'h0066);
        repeat (40) @(posedge mclk_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
        check_rst();
        chk(busy_out === 1'b0, "busy in reset");
        reset_n_in <= 1'b1;
        send(9'h166);
        $display("test midreset done");
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // About 22 words of about 200 cycles each, with a wide margin
    initial
    begin
        repeat (30000) @(posedge mclk_in);
        num_errors++;
        $display("Error at %0t: watchdog", $time);
        finish_test();
    end
    initial
    begin
        reset_n_in = 1'b0;
        cmd_addr_in = 4'h0;
        cmd_wdata_in = 16'h0000;
        cmd_wr_in = 1'b0;
        cmd_rd_in = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge mclk_in);
        #1;
        check_rst();
        @(posedge mclk_in);
        reset_n_in <= 1'b1;
        test_codes();
        test_regs();
        test_midreset();
        finish_test();
    end
endmodule
`default_nettype wire
